// ---- uds_pkg.sv ----
// Constants shared by the serial port data path and its receiver.
// Assumes a single 10 MHz system clock domain.
package uds_pkg;
   localparam logic [2:0] A_STAT = 3'h0;
   localparam logic [2:0] A_CTLA = 3'h1;
   localparam logic [2:0] A_CTLB = 3'h2;
   localparam logic [2:0] A_DATA = 3'h3;
   localparam logic [2:0] A_BAUD = 3'h4;
   // serial_control_a fields
   localparam int B_UE = 7;
   localparam int B_NINE = 6;
   localparam int B_PEN = 5;
   localparam int B_ODD = 4;
   localparam int B_STOP_BIT_COUNT_SELECT = 3;
   localparam int B_BRK = 2;
   localparam int B_RX8 = 1;
   localparam int B_TX8 = 0;
   // serial_control_b fields
   localparam int B_TRANSMITTER_ENABLE = 7;
   localparam int B_RECEIVER_ENABLE = 6;
   localparam int B_RIE = 2;
   localparam logic [7:0] RST_STAT = 8'h0B;
   localparam logic [7:0] RST_CTL = 8'h00;
   localparam logic [7:0] RST_BAUD = 8'h00;
   // Sixteen baud ticks per bit; majority of ticks 7..9
   localparam logic [3:0] SUB_LAST = 4'hF;
   localparam logic [3:0] SMP_LO = 4'h7;
   localparam logic [3:0] SMP_HI = 4'h9;
   localparam logic [3:0] SMP_EVAL = 4'hA;
   localparam logic [3:0] FRM_BASE = 4'hA;
   localparam int FIFO_DEPTH = 2;

   // Parity bit over 8 or 9 data bits
   function automatic logic uds_par(logic [8:0] d, logic nine,
                                    logic odd);
      return (^(d & {nine, 8'hFF})) ^ odd;
   endfunction : uds_par
endpackage : uds_pkg

// ---- uds_rx_if.sv ----
// Link between the port core and its receive shift logic.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface uds_rx_if;
   logic tick;
   logic en;
   logic nine;
   logic par_en;
   logic par_odd;
   logic done;
   logic busy;
   logic framing_error_flag;
   logic parity_error_flag;
   logic noise;
   logic [8:0] data;
   modport ctl(output tick, en, nine, par_en, par_odd,
               input done, busy, framing_error_flag, parity_error_flag, noise, data);
   modport rx(input tick, en, nine, par_en, par_odd,
              output done, busy, framing_error_flag, parity_error_flag, noise, data);
endinterface : uds_rx_if

// ---- uds_rx.sv ----
// Receive shift register with start, data, parity and stop sampling.
// Assumes tick at sixteen times the bit rate and a synchronous input.
`timescale 1ns/10ps
module uds_rx import uds_pkg::*; (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic rx_i,
   uds_rx_if.rx rif
);
   typedef enum logic [2:0] {
      R_IDLE = 3'b000,
      R_START = 3'b001,
      R_DATA = 3'b010,
      R_PAR = 3'b011,
      R_STOP = 3'b100
   } uds_rxst_e;

   uds_rxst_e st_q;
   logic [3:0] sub_q;
   logic [3:0] bit_q;
   logic [8:0] sh_q;
   logic [2:0] smp_q;
   logic nz_q;
   logic pb_q;
   logic maj;
   logic dis;
   logic eval;
   logic [8:0] word;

   assign maj = (smp_q[0] & smp_q[1]) | (smp_q[0] & smp_q[2])
              | (smp_q[1] & smp_q[2]);
   assign dis = (|smp_q) & ~(&smp_q);
   assign eval = rif.tick && sub_q == SMP_EVAL;
   assign word = rif.nine ? sh_q : {1'b0, sh_q[8:1]};
   assign rif.busy = st_q != R_IDLE;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= R_IDLE;
         sub_q <= 4'h0;
         bit_q <= 4'h0;
         sh_q <= 9'h000;
         smp_q <= 3'h7;
         nz_q <= 1'b0;
         pb_q <= 1'b0;
         rif.done <= 1'b0;
         rif.framing_error_flag <= 1'b0;
         rif.parity_error_flag <= 1'b0;
         rif.noise <= 1'b0;
         rif.data <= 9'h000;
      end else begin
         rif.done <= 1'b0;
         if (!rif.en) begin
            st_q <= R_IDLE;
            sub_q <= 4'h0;
         end else if (rif.tick) begin
            if (st_q == R_IDLE) begin
               sub_q <= 4'h1;
               if (!rx_i) begin
                  st_q <= R_START;
               end
            end else begin
               sub_q <= sub_q + 4'h1;
            end
            if (sub_q >= SMP_LO && sub_q <= SMP_HI) begin
               smp_q <= {smp_q[1:0], rx_i};
            end
            if (eval) begin
               unique case (st_q)
                  R_IDLE: begin
                  end
                  R_START: begin
                     st_q <= maj ? R_IDLE : R_DATA;
                     nz_q <= dis;
                     bit_q <= 4'h0;
                  end
                  R_DATA: begin
                     sh_q <= {maj, sh_q[8:1]};
                     nz_q <= nz_q | dis;
                     bit_q <= bit_q + 4'h1;
                     if (bit_q == (rif.nine ? 4'h8 : 4'h7)) begin
                        st_q <= rif.par_en ? R_PAR : R_STOP;
                     end
                  end
                  R_PAR: begin
                     pb_q <= maj;
                     nz_q <= nz_q | dis;
                     st_q <= R_STOP;
                  end
                  R_STOP: begin
                     st_q <= R_IDLE;
                     rif.done <= 1'b1;
                     rif.data <= word;
                     rif.framing_error_flag <= ~maj;
                     rif.noise <= nz_q | dis;
                     rif.parity_error_flag <= rif.par_en &
                        (uds_par(word, rif.nine, rif.par_odd) != pb_q);
                  end
               endcase
            end
         end
      end
   end
endmodule : uds_rx

// ---- uds_top.sv ----
// Serial port data path: shared data register, status flags, shifters.
// Assumes synchronous register strobes from the processor data bus.
`timescale 1ns/10ps
// Operation
// - Written byte shifts out LSB first
// - Received bits shift in LSB first
// - One shared data address, shifters hidden
// - Enables drive pins, otherwise pins float
// - Status flags are read only
// - Parity error flag in bit 7
// - Noise flag bit 6, not on overrun
// - Framing error flag in bit 5
// - Overrun flag bit 4 blocks transfers
// - Status read then data access clears errors
// - Receiver idle low during a frame
// - Receive full bit 2, optional interrupt
// - Error flags set with receive full
// - Receive full clears after sequence, empty
// - Transmitter idle bit 1, pin high
// - Status read then write clears idle
// - No idle while data or break queued
// - Transmit empty bit 0 on load
// - Status read then write clears empty
// - Transmitter enable sets transmit empty
// - Two entry receive queue
// - Port disable flushes and resets flags
// - Ninth bit in control register bits
// - Stop bit select one or two
module uds_top import uds_pkg::*; (
   input wire logic CLK,
   input wire logic RSTN,
   input wire logic [2:0] REG_ADDR,
   input wire logic REG_WR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_WDATA,
   output logic [7:0] REG_RDATA,
   input wire logic RX_I,
   output logic TX_O,
   output logic TX_OE,
   output logic RX_PULL_OFF,
   output logic RX_IRQ
);
   logic [7:0] ctla_q;
   logic [7:0] ctlb_q;
   logic [7:0] baud_q;
   logic [7:0] bcnt_q;
   logic tick_q;
   logic port_en;
   logic tx_on;
   logic rx_on;
   logic rd_stat;
   logic rd_data;
   logic wr_data;
   logic data_acc;
   logic [8:0] fifo_mem [FIFO_DEPTH];
   logic rp_q;
   logic wp_q;
   logic [1:0] cnt_q;
   logic push;
   logic pop;
   logic ovr;
   logic parity_error_flag_q;
   logic nf_q;
   logic framing_error_flag_q;
   logic overrun_flag_q;
   logic receive_full_flag_q;
   logic transmitter_idle_flag_q;
   logic transmit_empty_flag_q;
   logic sseen_q;
   logic rxs_q;
   logic txs_q;
   logic tis_q;
   logic [7:0] stat;
   logic [8:0] tbuf_q;
   logic tfull_q;
   logic [11:0] tsh_q;
   logic [3:0] tbits_q;
   logic [3:0] tsub_q;
   logic tbusy;
   logic load;
   logic brk;
   logic shift;
   logic tx_free;

   uds_rx_if rif();

   function automatic logic [11:0] uds_frame(logic [8:0] d,
      logic nine, logic pen, logic odd);
      logic [11:0] f;
      logic p;
      f = 12'hFFF;
      p = uds_par(d, nine, odd);
      f[0] = 1'b0;
      f[8:1] = d[7:0];
      if (nine) begin
         f[9] = d[8];
         if (pen) begin
            f[10] = p;
         end
      end else if (pen) begin
         f[9] = p;
      end
      return f;
   endfunction : uds_frame

   assign port_en = ctla_q[B_UE];
   assign tx_on = port_en & ctlb_q[B_TRANSMITTER_ENABLE];
   assign rx_on = port_en & ctlb_q[B_RECEIVER_ENABLE];
   assign rd_stat = REG_RD && REG_ADDR == A_STAT;
   assign rd_data = REG_RD && REG_ADDR == A_DATA;
   assign wr_data = REG_WR && REG_ADDR == A_DATA;
   assign data_acc = rd_data | wr_data;

   assign rif.tick = tick_q;
   assign rif.en = rx_on;
   assign rif.nine = ctla_q[B_NINE];
   assign rif.par_en = ctla_q[B_PEN];
   assign rif.par_odd = ctla_q[B_ODD];

   uds_rx u_rx (
      .clk(CLK),
      .rst_n(RSTN),
      .rx_i(RX_I),
      .rif(rif)
   );

   // Control registers; status has no write path
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         ctla_q <= RST_CTL;
         ctlb_q <= RST_CTL;
         baud_q <= RST_BAUD;
      end else begin
         if (REG_WR && REG_ADDR == A_CTLA) begin
            ctla_q <= REG_WDATA;
         end
         if (REG_WR && REG_ADDR == A_CTLB) begin
            ctlb_q <= REG_WDATA;
         end
         if (REG_WR && REG_ADDR == A_BAUD) begin
            baud_q <= REG_WDATA;
         end
         if (!port_en) begin
            ctlb_q[B_TRANSMITTER_ENABLE] <= 1'b0;
            ctlb_q[B_RECEIVER_ENABLE] <= 1'b0;
            ctla_q[B_BRK] <= 1'b0;
         end
      end
   end

   // Baud tick at sixteen times the bit rate
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         bcnt_q <= 8'h00;
         tick_q <= 1'b0;
      end else if (!port_en) begin
         bcnt_q <= 8'h00;
         tick_q <= 1'b0;
      end else if (bcnt_q == 8'h00) begin
         bcnt_q <= baud_q;
         tick_q <= 1'b1;
      end else begin
         bcnt_q <= bcnt_q - 8'h01;
         tick_q <= 1'b0;
      end
   end

   // Receive queue
   assign ovr = rif.done && (cnt_q == 2'd2 || overrun_flag_q);
   assign push = rif.done && !ovr && rx_on;
   assign pop = rd_data && cnt_q != 2'd0;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         rp_q <= 1'b0;
         wp_q <= 1'b0;
         cnt_q <= 2'd0;
         for (int i = 0; i < FIFO_DEPTH; i++) begin
            fifo_mem[i] <= 9'h000;
         end
      end else if (!port_en) begin
         rp_q <= 1'b0;
         wp_q <= 1'b0;
         cnt_q <= 2'd0;
      end else begin
         if (push) begin
            fifo_mem[wp_q] <= rif.data;
            wp_q <= ~wp_q;
         end
         if (pop) begin
            rp_q <= ~rp_q;
         end
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

   // Status read half of the clearing sequences
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         sseen_q <= 1'b0;
         rxs_q <= 1'b0;
         txs_q <= 1'b0;
         tis_q <= 1'b0;
      end else if (rd_stat) begin
         sseen_q <= 1'b1;
         rxs_q <= receive_full_flag_q;
         txs_q <= transmit_empty_flag_q;
         tis_q <= transmitter_idle_flag_q;
      end else if (data_acc || !port_en) begin
         sseen_q <= 1'b0;
         rxs_q <= 1'b0;
         txs_q <= 1'b0;
         tis_q <= 1'b0;
      end
   end

   // Receive flags; a new event beats a clear
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         parity_error_flag_q <= RST_STAT[7];
         nf_q <= RST_STAT[6];
         framing_error_flag_q <= RST_STAT[5];
         overrun_flag_q <= RST_STAT[4];
         receive_full_flag_q <= RST_STAT[2];
      end else if (!port_en) begin
         parity_error_flag_q <= 1'b0;
         nf_q <= 1'b0;
         framing_error_flag_q <= 1'b0;
         overrun_flag_q <= 1'b0;
         receive_full_flag_q <= 1'b0;
      end else begin
         if (push) begin
            receive_full_flag_q <= 1'b1;
            parity_error_flag_q <= parity_error_flag_q | rif.parity_error_flag;
            nf_q <= nf_q | rif.noise;
            framing_error_flag_q <= framing_error_flag_q | rif.framing_error_flag;
         end else if (data_acc && sseen_q) begin
            parity_error_flag_q <= 1'b0;
            nf_q <= 1'b0;
            framing_error_flag_q <= 1'b0;
         end
         if (ovr) begin
            overrun_flag_q <= 1'b1;
         end else if (data_acc && sseen_q) begin
            overrun_flag_q <= 1'b0;
         end
         if (!push && rd_data && rxs_q && cnt_q == 2'd1) begin
            receive_full_flag_q <= 1'b0;
         end
      end
   end

   // Transmit holding buffer and shifter
   assign tbusy = tbits_q != 4'h0;
   assign load = tx_on && tfull_q && !tbusy;
   assign brk = ctla_q[B_BRK] && !tfull_q && !tbusy;
   assign shift = tick_q && tbusy && tsub_q == SUB_LAST;
   assign tx_free = !tfull_q && !tbusy && !brk;

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         tbuf_q <= 9'h000;
         tfull_q <= 1'b0;
      end else if (!tx_on) begin
         tfull_q <= 1'b0;
      end else if (wr_data) begin
         tbuf_q <= {ctla_q[B_TX8], REG_WDATA};
         tfull_q <= 1'b1;
      end else if (load) begin
         tfull_q <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         tsh_q <= 12'hFFF;
         tbits_q <= 4'h0;
         tsub_q <= 4'h0;
      end else if (!tx_on) begin
         tbits_q <= 4'h0;
         tsub_q <= 4'h0;
      end else if (load) begin
         tsh_q <= uds_frame(tbuf_q, ctla_q[B_NINE], ctla_q[B_PEN],
                            ctla_q[B_ODD]);
         tbits_q <= FRM_BASE + {3'h0, ctla_q[B_NINE]}
                  + {3'h0, ctla_q[B_PEN]}
                  + {3'h0, ctla_q[B_STOP_BIT_COUNT_SELECT]};
         tsub_q <= 4'h0;
      end else if (tick_q && tbusy) begin
         tsub_q <= tsub_q + 4'h1;
         if (shift) begin
            tsh_q <= {1'b1, tsh_q[11:1]};
            tbits_q <= tbits_q - 4'h1;
         end
      end
   end

   // Transmit flags
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         transmit_empty_flag_q <= RST_STAT[0];
         transmitter_idle_flag_q <= RST_STAT[1];
      end else begin
         if (!tx_on || load) begin
            transmit_empty_flag_q <= 1'b1;
         end else if (wr_data && txs_q) begin
            transmit_empty_flag_q <= 1'b0;
         end
         if (tfull_q || tbusy || brk || wr_data) begin
            transmitter_idle_flag_q <= 1'b0;
         end else if (transmit_empty_flag_q || !tx_on) begin
            transmitter_idle_flag_q <= 1'b1;
         end
         if (wr_data && tis_q) begin
            transmitter_idle_flag_q <= 1'b0;
         end
      end
   end

   assign stat = {parity_error_flag_q, nf_q, framing_error_flag_q, overrun_flag_q, ~rif.busy,
                  receive_full_flag_q, transmitter_idle_flag_q, transmit_empty_flag_q};

   // Pins, interrupt and read data
   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         TX_O <= 1'b1;
         TX_OE <= 1'b0;
         RX_PULL_OFF <= 1'b0;
         RX_IRQ <= 1'b0;
      end else begin
         TX_OE <= tx_on;
         RX_PULL_OFF <= rx_on;
         TX_O <= brk ? 1'b0 : (tbusy ? tsh_q[0] : 1'b1);
         RX_IRQ <= receive_full_flag_q & ctlb_q[B_RIE];
      end
   end

   always_ff @(posedge CLK or negedge RSTN) begin
      if (!RSTN) begin
         REG_RDATA <= 8'h00;
      end else if (REG_RD) begin
         unique case (REG_ADDR)
            A_STAT: REG_RDATA <= stat;
            A_CTLA: REG_RDATA <= {ctla_q[7:2],
                                  fifo_mem[rp_q][8], 1'b0};
            A_CTLB: REG_RDATA <= ctlb_q;
            A_DATA: REG_RDATA <= fifo_mem[rp_q][7:0];
            A_BAUD: REG_RDATA <= baud_q;
            default: REG_RDATA <= 8'h00;
         endcase
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RSTN);

   a_receive_full_flag_on_push: assert property (push |=> receive_full_flag_q)
      else $error("receive full not set on transfer");
   a_err_with_full: assert property (
      $rose(framing_error_flag_q) || $rose(parity_error_flag_q) || $rose(nf_q)
      |-> $rose(receive_full_flag_q) || (receive_full_flag_q && $past(push)))
      else $error("error flag without transfer");
   a_ovr_sets: assert property (
      port_en && rif.done && cnt_q == 2'd2 |=> overrun_flag_q && !$rose(nf_q))
      else $error("overrun not flagged");
   a_ovr_blocks: assert property (
      overrun_flag_q && port_en |=> $stable(wp_q))
      else $error("transfer during overrun");
   a_err_clear: assert property (
      port_en && sseen_q && data_acc && !rif.done
      |=> !parity_error_flag_q && !nf_q && !framing_error_flag_q && !overrun_flag_q)
      else $error("error flags not cleared");
   a_transmitter_idle_flag_queue: assert property (
      transmitter_idle_flag_q |-> $past(tx_free))
      else $error("idle while data queued");
   a_transmit_empty_flag_clear: assert property (
      tx_on && wr_data && txs_q && !load |=> !transmit_empty_flag_q)
      else $error("transmit empty not cleared");
   a_transmitter_enable_transmit_empty_flag: assert property (
      port_en && $rose(ctlb_q[B_TRANSMITTER_ENABLE]) |-> transmit_empty_flag_q)
      else $error("enable did not show empty");
   a_tx_start: assert property (
      load ##1 tx_on |=> !TX_O && TX_OE)
      else $error("start bit missing");
   a_pin_float: assert property (
      !port_en |=> !TX_OE && !RX_PULL_OFF)
      else $error("pin driven while disabled");

   c_rx_parity: cover property (push && rif.parity_error_flag);
   c_overrun: cover property ($rose(overrun_flag_q));
   c_queue_full: cover property (cnt_q == 2'd2);
   c_tx_idle: cover property ($rose(transmitter_idle_flag_q));
endmodule : uds_top

// ---- uds_peer.sv ----
// Far serial device: sends frames on RX and collects frames from TX.
// Assumes one bit lasts BIT_CLKS cycles of clk and an idle-high line.
`timescale 1ns/10ps
module uds_peer #(
   parameter int BIT_CLKS = 16
) (
   input wire logic clk,
   input wire logic tx_i,
   input wire logic nine,
   output logic rx_o
);
   logic [8:0] got_q[$];
   logic [8:0] sh;

   initial rx_o = 1'b1;

   // Mid-bit sampling, LSB first
   always begin
      @(negedge tx_i);
      repeat (BIT_CLKS / 2) @(negedge clk);
      if (tx_i === 1'b0) begin
         sh = '0;
         for (int i = 0; i < (nine ? 9 : 8); i++) begin
            repeat (BIT_CLKS) @(negedge clk);
            sh[i] = tx_i;
         end
         repeat (BIT_CLKS) @(negedge clk);
         got_q.push_back(sh);
      end
   end

   // One bit time; optional one-cycle glitch mid bit, or a short low
   task automatic put(input logic b, input logic g, input int len);
      for (int k = 0; k < BIT_CLKS; k++) begin
         rx_o = (g && k == BIT_CLKS / 2) ? ~b : (k < len ? b : 1'b1);
         @(negedge clk);
      end
   endtask : put

   // Frame: start, data LSB first, optional parity, stop
   task automatic send(input logic [8:0] d, input int nb, input logic pen,
                       input logic pbit, input logic stp, input logic g);
      @(negedge clk);
      put(1'b0, 1'b0, BIT_CLKS);
      for (int i = 0; i < nb; i++) begin
         put(d[i], g && i == 0, BIT_CLKS);
      end
      if (pen) begin
         put(pbit, 1'b0, BIT_CLKS);
      end
      // A low stop is cut short so no false start follows
      put(stp, 1'b0, stp ? BIT_CLKS : BIT_CLKS / 2 + 3);
      put(1'b1, 1'b0, BIT_CLKS);
   endtask : send
endmodule : uds_peer

// ---- uds_top_tb.sv ----
// Self-checking bench for the serial port data path and status flags.
// Assumes divisor 0, so one bit is sixteen system clocks.
`timescale 1ns/10ps
module uds_top_tb import uds_pkg::*; ;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic rx_line, tx_o, tx_oe, rx_pull_off, rx_irq;
   logic nine_q = 1'b0;
   logic [7:0] v, b0, b1;
   logic [7:0] r[3];
   logic pm, od;
   logic [2:0] e3;
   int mismatches = 0;
   int cmp_count = 0;

   always #50 clk = ~clk;

   uds_top uds_top_inst (.CLK(clk), .RSTN(rst_n), .REG_ADDR(reg_addr),
      .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_WDATA(reg_wdata),
      .REG_RDATA(reg_rdata), .RX_I(rx_line), .TX_O(tx_o), .TX_OE(tx_oe),
      .RX_PULL_OFF(rx_pull_off), .RX_IRQ(rx_irq));

   // Floated TX reads high through the pull-up
   uds_peer uds_peer_inst (.clk(clk), .tx_i(tx_oe ? tx_o : 1'b1),
      .nine(nine_q), .rx_o(rx_line));

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [8:0] got, input logic [8:0] exp,
                      input string m);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk);
      reg_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [2:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge clk);
      reg_rd = 1'b0;
      @(posedge clk);
      #1 d = reg_rdata;
   endtask : rd

   task automatic wait_rxf(output logic [7:0] s);
      int i;
      for (i = 0; i < 300; i++) begin
         rd(A_STAT, s);
         if (s[2] === 1'b1) break;
      end
      if (i == 300) begin
         mismatches++;
         $display("MISMATCH t=%0t no received data", $time);
         wrap_up();
      end
   endtask : wait_rxf

   task automatic wait_tx(input int n);
      int i;
      for (i = 0; i < 1000 && uds_peer_inst.got_q.size() < n; i++) begin
         @(negedge clk);
      end
      if (i == 1000) begin
         mismatches++;
         $display("MISMATCH t=%0t no frame on TX", $time);
         wrap_up();
      end
   endtask : wait_tx

   function automatic logic par_of(input logic [7:0] d, input logic odd);
      return (^d) ^ odd;
   endfunction : par_of

   initial begin
      void'($urandom(32'h2E16DF8A));
      repeat (5) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      // Reset state, read-only status, unmapped index
      chk({tx_o, tx_oe, rx_pull_off}, 3'h4, "pins after reset");
      wr(A_STAT, 8'hF4);
      rd(A_STAT, v);
      chk(v, RST_STAT, "status reset");
      rd(3'h5, v);
      chk(v, 8'h00, "unmapped read");
      wr(A_CTLB, 8'hC0);
      rd(A_CTLB, v);
      chk(v & 8'hC0, 8'h00, "enables without port");
      wr(A_CTLA, 8'h80);
      wr(A_CTLB, 8'hC4);
      @(negedge clk);
      chk({tx_oe, rx_pull_off}, 2'h3, "pins enabled");
      rd(A_STAT, v);
      chk(v, 8'h0B, "status enabled");
      // Back-to-back transmit, second byte waits in the buffer
      for (int n = 0; n < 3; n++) begin
         b0 = 8'($urandom);
         b1 = 8'($urandom);
         rd(A_STAT, v);
         wr(A_DATA, b0);
         rd(A_STAT, v);
         wr(A_DATA, b1);
         rd(A_STAT, v);
         chk(v[1:0], 2'h0, "buffer full");
         wait_tx(2);
         chk(uds_peer_inst.got_q.pop_front(), b0, "tx first");
         chk(uds_peer_inst.got_q.pop_front(), b1, "tx second");
         repeat (20) @(negedge clk);
         rd(A_STAT, v);
         chk({tx_o, v}, 9'h10B, "tx idle");
      end
      // Three characters into a two-entry queue
      for (int n = 0; n < 3; n++) begin
         r[n] = 8'($urandom);
      end
      fork
         uds_peer_inst.send({1'b0, r[0]}, 8, 1'b0, 1'b0, 1'b1, 1'b0);
         begin
            repeat (60) @(negedge clk);
            rd(A_STAT, v);
            chk(v[3], 1'b0, "receiver busy");
         end
      join
      wait_rxf(v);
      chk(rx_irq, 1'b1, "receive interrupt");
      uds_peer_inst.send({1'b0, r[1]}, 8, 1'b0, 1'b0, 1'b1, 1'b0);
      uds_peer_inst.send({1'b0, r[2]}, 8, 1'b0, 1'b0, 1'b1, 1'b0);
      rd(A_STAT, v);
      chk(v, 8'h1F, "overrun");
      rd(A_DATA, v);
      chk(v, r[0], "rx first");
      rd(A_STAT, v);
      chk(v, 8'h0F, "overrun cleared");
      rd(A_DATA, v);
      chk(v, r[1], "rx second");
      rd(A_STAT, v);
      chk({rx_irq, v}, 9'h00B, "queue empty");
      // Framing, even and odd parity errors, noise, clean odd parity
      for (int k = 0; k < 5; k++) begin
         b0 = 8'($urandom);
         pm = (k == 1 || k == 2 || k == 4);
         od = (k == 2 || k == 4);
         e3 = {k == 1 || k == 2, k == 3, k == 0};
         wr(A_CTLA, {2'h2, pm, od, 4'h0});
         uds_peer_inst.send({1'b0, b0}, 8, pm,
            par_of(b0, od) ^ (k == 1 || k == 2), k != 0, k == 3);
         wait_rxf(v);
         chk(v[7:5], e3, "errors");
         rd(A_DATA, v);
         chk(v, b0, "data with error");
         rd(A_STAT, v);
         chk(v, 8'h0B, "errors cleared");
      end
      // Nine-bit frames both ways
      b0 = 8'($urandom);
      wr(A_CTLA, 8'hC0);
      uds_peer_inst.send({1'b1, b0}, 9, 1'b0, 1'b0, 1'b1, 1'b0);
      wait_rxf(v);
      rd(A_CTLA, v);
      chk(v[1], 1'b1, "ninth bit in");
      rd(A_DATA, v);
      chk(v, b0, "nine-bit data");
      nine_q = 1'b1;
      wr(A_CTLA, 8'hC9);
      rd(A_STAT, v);
      wr(A_DATA, b0);
      wait_tx(1);
      chk(uds_peer_inst.got_q.pop_front(), {1'b1, b0}, "ninth out");
      // Second stop bit still on the line
      repeat (12) @(negedge clk);
      rd(A_STAT, v);
      chk(v[1], 1'b0, "second stop bit");
      nine_q = 1'b0;
      // Break holds TX low and the transmitter busy
      repeat (20) @(negedge clk);
      wr(A_CTLA, 8'h84);
      repeat (2) @(negedge clk);
      rd(A_STAT, v);
      chk({tx_o, v[1]}, 2'h0, "break");
      // Port disable with a character held
      wr(A_CTLA, 8'h80);
      uds_peer_inst.send({1'b0, b0}, 8, 1'b0, 1'b0, 1'b1, 1'b0);
      wait_rxf(v);
      chk(tx_o, 1'b1, "break released");
      wr(A_CTLA, 8'h00);
      rd(A_STAT, v);
      chk(v, 8'h0B, "flush status");
      rd(A_CTLB, v);
      chk({tx_oe, rx_pull_off, rx_irq, v}, 11'h004, "flush pins");
      wrap_up();
   end
endmodule : uds_top_tb
